// ### rtl/pmmc_pkg.sv
// Shared constants and types for the power-line modem mode control block.
// Assumes a single 10 MHz system clock; all times are converted to cycles here.
package pmmc_pkg;

  // ********************************************************************
  // Time base
  // ********************************************************************
  localparam longint unsigned CLK_HZ = 10000000;
  localparam int unsigned CLK_KHZ = 10000;

  // ********************************************************************
  // Times in their own units and derived cycle counts
  // ********************************************************************
  localparam int unsigned TX_TIMEOUT_MS = 1000;
  localparam int unsigned TX_TIMEOUT_CYC = TX_TIMEOUT_MS * CLK_KHZ;
  localparam int unsigned TX_SHORT_NS = 488000;
  localparam int unsigned TX_SHORT_CYC = TX_SHORT_NS / 100;
  localparam int unsigned WD_TIMEOUT_MS = 1500;
  localparam int unsigned WD_TIMEOUT_CYC = WD_TIMEOUT_MS * CLK_KHZ;
  localparam int unsigned WD_SHORT_NS = 46300;
  localparam int unsigned WD_SHORT_CYC = WD_SHORT_NS / 100;
  localparam int unsigned RST_HOLD_MS = 50;
  localparam int unsigned RST_HOLD_CYC = RST_HOLD_MS * CLK_KHZ;
  localparam int unsigned CD_QUAL_MS = 6;
  localparam int unsigned CD_QUAL_CYC = CD_QUAL_MS * CLK_KHZ;

  // ********************************************************************
  // Tone synthesis
  // ********************************************************************
  localparam int unsigned NCO_W = 24;
  localparam longint unsigned TONE0_HZ = 133050;
  localparam longint unsigned TONE1_HZ = 131850;
  localparam logic [NCO_W-1:0] TONE0_INC =
    NCO_W'((TONE0_HZ * (64'h1 << NCO_W) + CLK_HZ / 2) / CLK_HZ);
  localparam logic [NCO_W-1:0] TONE1_INC =
    NCO_W'((TONE1_HZ * (64'h1 << NCO_W) + CLK_HZ / 2) / CLK_HZ);

  // ********************************************************************
  // Counter widths and types
  // ********************************************************************
  localparam int unsigned CNT_W = 24;

  typedef enum logic [2:0] {
    PMMC_RX = 3'b001,
    PMMC_TX = 3'b010,
    PMMC_TIMED_OUT = 3'b100
  } pmmc_mode_t;

  typedef struct packed {
    logic autoswitch_disable;
    logic timeout_shorten;
    logic immediate_reset_in;
  } pmmc_test_t;

  typedef struct packed {
    logic amp_bias_ctl;
    logic amp_bias_ctl_n;
    logic line_drive_out;
    logic line_drive_oe_n;
  } pmmc_drive_t;

endpackage

// ### rtl/pmmc_top.sv
// Mode control, carrier qualification, watchdog and tone synthesis of the
// modem. Assumes all inputs are synchronous to clk and that line_sense_in is
// the output of the analog threshold comparator.
`timescale 1ns/1ps

// What this block does
// - Low direction selects transmit; one-second fall-back
// - Transmit bits accepted directly at host rate
// - Zero bit 133.05 kHz, one 131.85 kHz
// - All tones derived from one time base
// - Receive data held high in transmit
// - Receive path active only when direction high
// - Carrier absent forces receive data high
// - Low transmit data bypasses carrier clamp
// - No kick for 1.5 s raises reset
// - Reset output held at least 50 ms
// - Carrier detect asserts after 6 ms qualified
// - Carrier detect held 6 ms after loss
// - Receive or timeout: bias low, drive released
// - Test input disables automatic fall-back
// - Test input shortens transmit and watchdog timeouts
// - Immediate reset bypasses stretch delay
module pmmc_top #(
  parameter int unsigned TX_TIMEOUT = pmmc_pkg::TX_TIMEOUT_CYC,
  parameter int unsigned TX_SHORT = pmmc_pkg::TX_SHORT_CYC,
  parameter int unsigned WD_TIMEOUT = pmmc_pkg::WD_TIMEOUT_CYC,
  parameter int unsigned RST_HOLD = pmmc_pkg::RST_HOLD_CYC,
  parameter int unsigned CD_QUAL = pmmc_pkg::CD_QUAL_CYC,
  parameter int unsigned DATA_W = 1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic rx_not_tx,
  input wire logic tx_data,
  input wire logic kick_input,
  input wire logic line_sense_in,
  input wire logic [DATA_W-1:0] demod_data,
  input wire logic demod_valid,
  output logic demod_ready,
  input wire logic rx_ready,
  output logic [DATA_W-1:0] rx_data,
  output logic rx_valid,
  input wire pmmc_pkg::pmmc_test_t test_in,
  output logic carrier_present_n,
  output logic host_reset_out,
  output pmmc_pkg::pmmc_drive_t drive,
  output logic tx_active
);

  localparam int unsigned CW = pmmc_pkg::CNT_W;
  localparam int unsigned NW = pmmc_pkg::NCO_W;

  pmmc_pkg::pmmc_mode_t mode_reg;
  logic [CW-1:0] tx_cnt_reg;
  logic [CW-1:0] wd_cnt_reg;
  logic [CW-1:0] hold_cnt_reg;
  logic [CW-1:0] cd_cnt_reg;
  logic kick_prev_reg;
  logic [NW-1:0] nco_reg;
  logic [DATA_W-1:0] skid_reg;
  logic skid_valid_reg;
  logic skid_valid_next;
  logic imm;
  logic kick_fall;
  logic wd_trip;
  logic tx_expire;
  logic rx_on;
  logic in_fire;
  logic out_free;
  logic [DATA_W-1:0] in_word;
  logic [CW-1:0] tx_limit;
  logic [CW-1:0] wd_limit;

  // ********************************************************************
  // Common terms
  // ********************************************************************
  assign imm = test_in.immediate_reset_in;
  assign kick_fall = kick_prev_reg & ~kick_input;
  assign tx_limit = test_in.timeout_shorten ? CW'(TX_SHORT) : CW'(TX_TIMEOUT);
  assign wd_limit = test_in.timeout_shorten ? CW'(pmmc_pkg::WD_SHORT_CYC) : CW'(WD_TIMEOUT);
  assign wd_trip = (wd_cnt_reg >= wd_limit - CW'(1)) && !kick_fall;
  assign tx_expire = !test_in.autoswitch_disable && (tx_cnt_reg >= tx_limit - CW'(1));
  assign rx_on = (mode_reg == pmmc_pkg::PMMC_RX);

  // ********************************************************************
  // Mode state machine
  // ********************************************************************
  // Going back to receive on any high direction level; the host keeps the
  // two microsecond high time itself, so no minimum is enforced here.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_reg <= pmmc_pkg::PMMC_RX;
    end else if (imm) begin
      mode_reg <= pmmc_pkg::PMMC_RX;
    end else begin
      case (mode_reg)
        pmmc_pkg::PMMC_RX: begin
          if (!rx_not_tx) begin
            mode_reg <= pmmc_pkg::PMMC_TX;
          end
        end
        pmmc_pkg::PMMC_TX: begin
          if (rx_not_tx) begin
            mode_reg <= pmmc_pkg::PMMC_RX;
          end else if (tx_expire) begin
            mode_reg <= pmmc_pkg::PMMC_TIMED_OUT;
          end
        end
        pmmc_pkg::PMMC_TIMED_OUT: begin
          if (rx_not_tx) begin
            mode_reg <= pmmc_pkg::PMMC_RX;
          end else if (test_in.autoswitch_disable) begin
            mode_reg <= pmmc_pkg::PMMC_TX;
          end
        end
        default: begin
          mode_reg <= pmmc_pkg::PMMC_RX;
        end
      endcase
    end
  end

  // Transmit timeout counter
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_cnt_reg <= '0;
    end else if (imm || mode_reg != pmmc_pkg::PMMC_TX) begin
      tx_cnt_reg <= '0;
    end else if (tx_cnt_reg != {CW{1'b1}}) begin
      tx_cnt_reg <= tx_cnt_reg + CW'(1);
    end
  end

  // ********************************************************************
  // Watchdog and host reset
  // ********************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      kick_prev_reg <= 1'b0;
    end else begin
      kick_prev_reg <= kick_input;
    end
  end

  // Watchdog is held at zero while the host is held in reset, so it cannot
  // retrigger before the host has had a chance to start kicking.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wd_cnt_reg <= '0;
    end else if (imm || host_reset_out || kick_fall || wd_trip) begin
      wd_cnt_reg <= '0;
    end else begin
      wd_cnt_reg <= wd_cnt_reg + CW'(1);
    end
  end

  // Stretch counter; loaded at power-up so the host also sees a long reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hold_cnt_reg <= CW'(RST_HOLD - 1);
    end else if (imm) begin
      hold_cnt_reg <= '0;
    end else if (wd_trip && !host_reset_out) begin
      hold_cnt_reg <= CW'(RST_HOLD - 1);
    end else if (hold_cnt_reg != '0) begin
      hold_cnt_reg <= hold_cnt_reg - CW'(1);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      host_reset_out <= 1'b1;
    end else if (imm) begin
      host_reset_out <= 1'b1;
    end else begin
      host_reset_out <= (wd_trip && !host_reset_out) || (hold_cnt_reg != '0);
    end
  end

  // ********************************************************************
  // Carrier qualification
  // ********************************************************************
  // One counter serves both directions: it counts while the comparator
  // disagrees with the present state and clears when it agrees again.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cd_cnt_reg <= '0;
      carrier_present_n <= 1'b1;
    end else if (imm) begin
      cd_cnt_reg <= '0;
      carrier_present_n <= 1'b1;
    end else if (line_sense_in == carrier_present_n) begin
      // continuous presence qualifies; continuous loss releases
      if (cd_cnt_reg >= CW'(CD_QUAL - 1)) begin
        cd_cnt_reg <= '0;
        carrier_present_n <= ~carrier_present_n;
      end else begin
        cd_cnt_reg <= cd_cnt_reg + CW'(1);
      end
    end else begin
      cd_cnt_reg <= '0;
    end
  end

  // ********************************************************************
  // Tone synthesis and line drive
  // ********************************************************************
  // single time base accumulator; tone per data bit
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      nco_reg <= '0;
    end else if (mode_reg != pmmc_pkg::PMMC_TX) begin
      nco_reg <= '0;
    end else begin
      nco_reg <= nco_reg + (tx_data ? pmmc_pkg::TONE1_INC : pmmc_pkg::TONE0_INC);
    end
  end

  // bias and drive follow transmit state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      drive <= '{amp_bias_ctl: 1'b0, amp_bias_ctl_n: 1'b1,
                 line_drive_out: 1'b0, line_drive_oe_n: 1'b1};
      tx_active <= 1'b0;
    end else begin
      drive.amp_bias_ctl <= (mode_reg == pmmc_pkg::PMMC_TX) && !imm;
      drive.amp_bias_ctl_n <= !((mode_reg == pmmc_pkg::PMMC_TX) && !imm);
      drive.line_drive_out <= (mode_reg == pmmc_pkg::PMMC_TX) && nco_reg[NW-1];
      drive.line_drive_oe_n <= !((mode_reg == pmmc_pkg::PMMC_TX) && !imm);
      tx_active <= (mode_reg == pmmc_pkg::PMMC_TX) && !imm;
    end
  end

  // ********************************************************************
  // Receive clamp and two-entry buffer
  // ********************************************************************
  // ones outside receive; clamp without carrier; bypass
  assign in_word = (rx_on && (!carrier_present_n || !tx_data)) ? demod_data
                                                               : {DATA_W{1'b1}};
  assign in_fire = demod_valid && demod_ready;
  assign out_free = !rx_valid || rx_ready;

  // Skid slot fills only when the output slot is stalled
  always_comb begin
    skid_valid_next = skid_valid_reg;
    if (out_free) begin
      skid_valid_next = 1'b0;
    end else if (in_fire) begin
      skid_valid_next = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      skid_reg <= '0;
      skid_valid_reg <= 1'b0;
      demod_ready <= 1'b0;
    end else begin
      if (!out_free && in_fire) begin
        skid_reg <= in_word;
      end
      skid_valid_reg <= skid_valid_next;
      demod_ready <= !skid_valid_next;
    end
  end

  // Output slot; words leave in arrival order
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_data <= {DATA_W{1'b1}};
      rx_valid <= 1'b0;
    end else if (out_free) begin
      if (skid_valid_reg) begin
        rx_data <= skid_reg;
        rx_valid <= 1'b1;
      end else if (in_fire) begin
        rx_data <= in_word;
        rx_valid <= 1'b1;
      end else begin
        rx_valid <= 1'b0;
      end
    end
  end

endmodule

// ### test/pmmc_monitor.sv
// Port checker for the modem mode control block.
// Assumes it is bound into pmmc_top and takes over its shortened counts.
`timescale 1ns/1ps
module pmmc_monitor #(
  parameter int unsigned TX_TIMEOUT = 200,
  parameter int unsigned WD_TIMEOUT = 300,
  parameter int unsigned RST_HOLD = 40,
  parameter int unsigned CD_QUAL = 20
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic rx_not_tx,
  input wire logic kick_input,
  input wire logic line_sense_in,
  input wire pmmc_pkg::pmmc_test_t test_in,
  input wire logic carrier_present_n,
  input wire logic host_reset_out,
  input wire pmmc_pkg::pmmc_drive_t drive,
  input wire logic tx_active
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  int tx_cnt, hi_cnt, lo_cnt, idle_cnt, rst_cnt;
  logic kick_reg;
  // Run lengths of watched levels; int cannot wrap within a short run
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_cnt <= 0;
      hi_cnt <= 0;
      lo_cnt <= 0;
      idle_cnt <= 0;
      rst_cnt <= 0;
      kick_reg <= 1'h1;
    end else begin
      tx_cnt <= tx_active ? tx_cnt + 1 : 0;
      hi_cnt <= line_sense_in ? hi_cnt + 1 : 0;
      lo_cnt <= line_sense_in ? 0 : lo_cnt + 1;
      idle_cnt <= (host_reset_out || (kick_reg && !kick_input)) ? 0 : idle_cnt + 1;
      rst_cnt <= host_reset_out ? rst_cnt + 1 : 0;
      kick_reg <= kick_input;
    end
  end
  sequence s_released;
    ##2 !tx_active && !drive.amp_bias_ctl && drive.amp_bias_ctl_n && drive.line_drive_oe_n;
  endsequence
  property p_rx_mode;
    rx_not_tx |-> s_released;
  endproperty
  a_rx_mode: assert property (p_rx_mode) else $error("bias kept in receive");
  property p_tx_entry;
    $rose(tx_active) |-> !$past(rx_not_tx, 2);
  endproperty
  a_tx_entry: assert property (p_tx_entry) else $error("transmit without request");
  property p_tx_limit;
    tx_active && !test_in.autoswitch_disable |-> tx_cnt < TX_TIMEOUT;
  endproperty
  a_tx_limit: assert property (p_tx_limit) else $error("transmit too long");
  property p_imm_off;
    $fell(test_in.immediate_reset_in) |=> !host_reset_out;
  endproperty
  a_imm_off: assert property (p_imm_off) else $error("reset stretched");
  property p_rst_hold;
    $fell(host_reset_out) && !$past(test_in.immediate_reset_in, 2) |-> rst_cnt >= RST_HOLD;
  endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("reset pulse short");
  property p_cd_on;
    $fell(carrier_present_n) |-> hi_cnt >= CD_QUAL;
  endproperty
  a_cd_on: assert property (p_cd_on) else $error("detect too early");
  property p_cd_off;
    $rose(carrier_present_n) && !$past(test_in.immediate_reset_in) |-> lo_cnt >= CD_QUAL;
  endproperty
  a_cd_off: assert property (p_cd_off) else $error("detect dropped early");
  property p_wd_trip;
    $rose(host_reset_out) && !$past(test_in.immediate_reset_in)
      |-> idle_cnt + 2 >= (test_in.timeout_shorten ? 463 : WD_TIMEOUT);
  endproperty
  a_wd_trip: assert property (p_wd_trip) else $error("watchdog early");
endmodule

bind pmmc_top pmmc_monitor #(
  .TX_TIMEOUT(TX_TIMEOUT), .WD_TIMEOUT(WD_TIMEOUT), .RST_HOLD(RST_HOLD), .CD_QUAL(CD_QUAL)
) i_pmmc_monitor (
  .clk(clk), .arst_n(arst_n), .rx_not_tx(rx_not_tx), .kick_input(kick_input),
  .line_sense_in(line_sense_in), .test_in(test_in), .carrier_present_n(carrier_present_n),
  .host_reset_out(host_reset_out), .drive(drive), .tx_active(tx_active)
);

// ### test/pmmc_host.sv
// Host model: kicks the watchdog and consumes received words.
// Assumes the bench sets kick_en and stall at clock edges.
`timescale 1ns/1ps
module pmmc_host (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic kick_en,
  input wire logic stall,
  output logic kick_input,
  output logic rx_ready
);
  logic [5:0] div_reg;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_reg <= 6'h00;
      kick_input <= 1'h1;
    end else begin
      div_reg <= div_reg + 6'h01;
      if (kick_en && div_reg == 6'h3F) kick_input <= !kick_input;
    end
  end
  // Stall holds words in the buffer
  assign rx_ready = !stall;
endmodule

// ### test/test_pmmc_top.sv
// Self-checking bench for the modem mode control block.
// Assumes shortened counts; the host model kicks and drains words.
`timescale 1ns/1ps
module test_pmmc_top;
  localparam int TXT = 200;
  localparam int WDT = 300;
  localparam int RSTH = 40;
  localparam int CDQ = 20;
  logic clk = 1'h0, arst_n = 1'h0, rx_not_tx = 1'h1, tx_data = 1'h1, line_sense_in = 1'h0;
  logic demod_valid = 1'h0, kick_en = 1'h1, stall = 1'h0;
  logic [0:0] demod_data = 1'h0;
  pmmc_pkg::pmmc_test_t test_in = 3'h0;
  logic demod_ready, rx_valid, carrier_present_n, host_reset_out, tx_active, kick_input, rx_ready;
  logic [0:0] rx_data;
  pmmc_pkg::pmmc_drive_t drive;
  int failures = 0;
  int samples_checked = 0;
  pmmc_top #(.TX_TIMEOUT(TXT), .TX_SHORT(50), .WD_TIMEOUT(WDT), .RST_HOLD(RSTH), .CD_QUAL(CDQ))
    i_pmmc_top (.clk(clk), .arst_n(arst_n), .rx_not_tx(rx_not_tx), .tx_data(tx_data),
    .kick_input(kick_input), .line_sense_in(line_sense_in), .demod_data(demod_data),
    .demod_valid(demod_valid), .demod_ready(demod_ready), .rx_ready(rx_ready),
    .rx_data(rx_data), .rx_valid(rx_valid), .test_in(test_in), .drive(drive),
    .carrier_present_n(carrier_present_n), .host_reset_out(host_reset_out), .tx_active(tx_active));
  pmmc_host i_pmmc_host (.clk(clk), .arst_n(arst_n), .kick_en(kick_en), .stall(stall),
    .kick_input(kick_input), .rx_ready(rx_ready));
  initial forever #50 clk = ~clk;
  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'h1) begin
      failures++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask
  // A used-up bound is a hang: count it and close the run
  task automatic give_up(input int n, input int b);
    if (n >= b) begin
      failures++;
      end_sim;
    end
  endtask
  task automatic end_sim;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic t_power;
    int n = 0;
    chk(host_reset_out === 1'h1 && drive === 4'h5 && carrier_present_n === 1'h1, "rst");
    while (host_reset_out !== 1'h0 && n < 100) begin
      @(negedge clk);
      n++;
    end
    give_up(n, 100);
    chk(n >= RSTH - 2, "stretch");
  endtask
  task automatic t_tx;
    @(posedge clk) rx_not_tx <= 1'h0;
    wait_n(3);
    chk({tx_active, drive.amp_bias_ctl, drive.line_drive_oe_n} === 3'h6, "tx on");
    wait_n(TXT - 6);
    chk(tx_active === 1'h1, "tx early end");
    wait_n(28);
    chk(tx_active === 1'h0 && drive === 4'h5, "fall-back");
    @(posedge clk) rx_not_tx <= 1'h1;
    wait_n(25);
  endtask
  // Rising edges over 1 ms give the tone in kHz
  task automatic t_tone(input logic b, input int lo, input int hi);
    int n = 0;
    logic last;
    @(posedge clk) tx_data <= b;
    wait_n(2);
    last = drive.line_drive_out;
    repeat (10000) begin
      @(negedge clk);
      if (drive.line_drive_out && !last) n++;
      last = drive.line_drive_out;
    end
    chk(n >= lo && n <= hi, "tone");
  endtask
  task automatic t_modes;
    @(posedge clk) test_in <= 3'h4;
    rx_not_tx <= 1'h0;
    wait_n(TXT + 20);
    chk(tx_active === 1'h1, "no fall-back");
    t_tone(1'h0, 133, 134);
    t_tone(1'h1, 131, 132);
    @(posedge clk) rx_not_tx <= 1'h1;
    wait_n(25);
    @(posedge clk) test_in <= 3'h2;
    rx_not_tx <= 1'h0;
    wait_n(56);
    chk(tx_active === 1'h0, "short");
    @(posedge clk) rx_not_tx <= 1'h1;
    wait_n(25);
    @(posedge clk) test_in <= 3'h0;
  endtask
  task automatic send(input logic d, input logic e, input string m);
    int n = 0;
    @(posedge clk) demod_data <= d;
    demod_valid <= 1'h1;
    @(posedge clk) demod_valid <= 1'h0;
    wait_n(1);
    while (rx_valid !== 1'h1 && n < 10) begin
      @(negedge clk);
      n++;
    end
    give_up(n, 10);
    chk(rx_data === e, m);
  endtask
  task automatic t_stream;
    @(posedge clk) rx_not_tx <= 1'h0;
    wait_n(3);
    send(1'h0, 1'h1, "tx clamp");
    @(posedge clk) rx_not_tx <= 1'h1;
    wait_n(25);
    send(1'h0, 1'h1, "cd clamp");
    @(posedge clk) tx_data <= 1'h0;
    send(1'h0, 1'h0, "bypass");
    @(posedge clk) tx_data <= 1'h1;
    line_sense_in <= 1'h1;
    wait_n(CDQ - 3);
    chk(carrier_present_n === 1'h1, "cd early");
    wait_n(5);
    chk(carrier_present_n === 1'h0, "cd late");
    send(1'h0, 1'h0, "cd data");
    @(posedge clk) line_sense_in <= 1'h0;
    wait_n(CDQ - 3);
    chk(carrier_present_n === 1'h0, "cd hold");
    wait_n(5);
    chk(carrier_present_n === 1'h1, "cd off");
  endtask
  // Fill both slots with the consumer stalled, then drain
  task automatic t_buffer;
    logic [0:0] q[$];
    @(posedge clk) stall <= 1'h1;
    tx_data <= 1'h0;
    demod_valid <= 1'h1;
    @(posedge clk) demod_data <= 1'h1;
    repeat (3) @(posedge clk);
    wait_n(1);
    chk(demod_ready === 1'h0 && rx_valid === 1'h1, "full");
    @(posedge clk) demod_valid <= 1'h0;
    stall <= 1'h0;
    repeat (4) begin
      @(negedge clk);
      if (rx_valid === 1'h1) q.push_back(rx_data);
    end
    chk(q.size() == 2 && q[0] === 1'h0 && q[1] === 1'h1 && demod_ready === 1'h1, "drain");
    @(posedge clk) tx_data <= 1'h1;
  endtask
  task automatic t_wd;
    int n = 0;
    @(posedge clk) kick_en <= 1'h0;
    while (host_reset_out !== 1'h1 && n < 500) begin
      @(negedge clk);
      n++;
    end
    give_up(n, 500);
    chk(n > WDT - 130 && n <= WDT + 3, "trip");
    @(posedge clk) kick_en <= 1'h1;
    wait_n(1);
    t_power;
    @(posedge clk) test_in <= 3'h1;
    wait_n(2);
    chk(host_reset_out === 1'h1, "imm on");
    @(posedge clk) test_in <= 3'h0;
    wait_n(2);
    chk(host_reset_out === 1'h0, "imm off");
    // Shortened watchdog limit with kicks stopped
    @(posedge clk) test_in <= 3'h2;
    kick_en <= 1'h0;
    n = 0;
    while (host_reset_out !== 1'h1 && n < 700) begin
      @(negedge clk);
      n++;
    end
    give_up(n, 700);
    chk(n > pmmc_pkg::WD_SHORT_CYC - 130 && n <= pmmc_pkg::WD_SHORT_CYC + 3, "short trip");
    @(posedge clk) kick_en <= 1'h1;
    test_in <= 3'h0;
    wait_n(1);
    t_power;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1'h1;
    wait_n(1);
    t_power;
    t_tx;
    t_modes;
    t_stream;
    t_buffer;
    t_wd;
    end_sim;
  end
endmodule
